/* File: core/yearly_date_timer.sv */
// Yearly date timer: switches one output on calendar dates at midnight.
// Assumes a scan strobe from the program logic and a calendar source
// that presents year, month, day and time of day every scan.
`timescale 1ns/1ps
module yearly_date_timer
  import ydt_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [31:0] RDATA_O,
  input  wire logic        SCAN_I,
  input  wire date_t       CAL_DATE_I,
  input  wire logic [4:0]  CAL_HOUR_I,
  input  wire logic [5:0]  CAL_MIN_I,
  output logic             TIMER_Q_O
);

  typedef enum logic [1:0] {ST_OFF, ST_ON, ST_PULSE} state_t;

  // Configuration registers
  logic [31:0] ctrl;
  logic [31:0] on_word;
  logic [31:0] off_word;
  logic        spent;
  state_t      state;
  state_t      next_state;
  logic        next_spent;

  // Register write decode
  wire wr_ctrl = WR_I && (ADDR_I == CTRL_OFF);
  wire wr_on   = WR_I && (ADDR_I == ON_OFF);
  wire wr_off  = WR_I && (ADDR_I == OFFD_OFF);

  // Ordered date fields and options
  date_t on_date;
  date_t off_date;
  mode_t mode;
  assign on_date      = to_date(on_word);
  assign off_date     = to_date(off_word);
  assign mode.yearly  = ctrl[CTRL_YEARLY];
  assign mode.monthly = ctrl[CTRL_MONTHLY];
  assign mode.pulse   = ctrl[CTRL_PULSE];

  wire repeating    = mode.yearly || mode.monthly;
  wire pulse_single = mode.pulse && !repeating;

  // Field range checks
  function automatic logic year_ok(input logic [11:0] y);
    year_ok = (y >= YEAR_MIN) && (y <= YEAR_MAX);
  endfunction

  function automatic logic md_ok(input date_t d, input logic any_month);
    md_ok = (d.day != 5'h00) && (d.day <= DAY_MAX) &&
            (any_month || (d.month != 4'h0 && d.month <= MONTH_MAX));
  endfunction

  // On date must be valid, its month only outside monthly mode; off date only as far as the mode reads it
  wire on_ok  = year_ok(on_date.year) &&
                md_ok(on_date, mode.monthly);
  wire off_ok = pulse_single ? 1'b1 :
                !year_ok(off_date.year) ? 1'b0 :
                mode.pulse ? 1'b1 : md_ok(off_date, mode.monthly);
  wire cfg_ok = on_ok && off_ok;

  // Scan-paced day change detection
  logic eval_now;
  logic restore;
  day_change_detect u_day (
    .clk_i     (CLK_I),
    .rst_i     (RST_I),
    .scan_i    (SCAN_I),
    .date_i    (CAL_DATE_I),
    .hour_i    (CAL_HOUR_I),
    .min_i     (CAL_MIN_I),
    .eval_o    (eval_now),
    .restore_o (restore)
  );

  // Schedule evaluation against the current date
  logic active;
  logic hit;
  schedule_eval u_eval (
    .mode_date_i (CAL_DATE_I),
    .on_i        (on_date),
    .off_i       (off_date),
    .mode_i      (mode),
    .active_o    (active),
    .hit_o       (hit)
  );

  // Pulse permitted unless the single occurrence was used
  wire pulse_go = cfg_ok && hit && !(pulse_single && spent);

  // Output state decision, taken only on a scan: a judging scan, a restoring scan outside pulse mode, or any scan that ends a pulse
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF, ST_ON: begin
        if (eval_now || (restore && !mode.pulse)) begin
          if (mode.pulse) begin
            next_state = (eval_now && pulse_go) ? ST_PULSE : ST_OFF;
          end else begin
            next_state = (cfg_ok && active) ? ST_ON : ST_OFF;
          end
        end
      end
      ST_PULSE: begin
        if (SCAN_I) begin
          next_state = ST_OFF;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  // Single pulse used up; a new firing wins over a clearing write
  always_comb begin
    next_spent = spent;
    if (wr_ctrl || wr_on) begin
      next_spent = 1'b0;
    end
    if (next_state == ST_PULSE && state != ST_PULSE && pulse_single) begin
      next_spent = 1'b1;
    end
  end

  // Configuration writes
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctrl     <= CTRL_RST;
      on_word  <= DATE_RST;
      off_word <= DATE_RST;
    end else begin
      if (wr_ctrl) ctrl <= WDATA_I & 32'h0000_0007;
      if (wr_on)   on_word <= to_word(to_date(WDATA_I));
      if (wr_off)  off_word <= to_word(to_date(WDATA_I));
    end
  end

  // Output state and registered output
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state     <= ST_OFF;
      spent     <= 1'b0;
      TIMER_Q_O <= 1'b0;
    end else begin
      state     <= next_state;
      spent     <= next_spent;
      TIMER_Q_O <= (next_state != ST_OFF);
    end
  end

  // Read data selection
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_OUT]   = TIMER_Q_O;
    status_word[STAT_ON_OK] = on_ok;
    status_word[STAT_OF_OK] = off_ok;
    status_word[STAT_SPENT] = spent;
  end

  assign rd_mux = (ADDR_I == CTRL_OFF)   ? ctrl :
                  (ADDR_I == ON_OFF)     ? on_word :
                  (ADDR_I == OFFD_OFF)   ? off_word :
                  (ADDR_I == STATUS_OFF) ? status_word :
                  (ADDR_I == NOW_OFF)    ? to_word(CAL_DATE_I) :
                                           32'h0000_0000;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      RDATA_O <= 32'h0000_0000;
    end else begin
      RDATA_O <= RD_I ? rd_mux : 32'h0000_0000;
    end
  end

  // Checks on the schedule behaviour
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  property p_midnight_only;
    $changed(TIMER_Q_O) |->
      $past(eval_now) || $past(restore) || $past(state == ST_PULSE);
  endproperty
  a_midnight_only: assert property (p_midnight_only)
    else $error("Output changed outside a midnight judgement");

  property p_pulse_one_scan;
    (state == ST_PULSE && SCAN_I) |=> !TIMER_Q_O;
  endproperty
  a_pulse_one_scan: assert property (p_pulse_one_scan)
    else $error("Pulse lasted beyond one scan");

  property p_pulse_fires;
    (eval_now && mode.pulse && cfg_ok && hit && !(pulse_single && spent)
     && state != ST_PULSE) |=> TIMER_Q_O && state == ST_PULSE;
  endproperty
  a_pulse_fires: assert property (p_pulse_fires)
    else $error("Pulse did not fire on a matching date");

  property p_single_once;
    (spent && pulse_single && !wr_ctrl && !wr_on && state != ST_PULSE)
      |=> state != ST_PULSE;
  endproperty
  a_single_once: assert property (p_single_once)
    else $error("Single pulse fired a second time");

  property p_range;
    (eval_now && !cfg_ok) |=> !TIMER_Q_O;
  endproperty
  a_range: assert property (p_range)
    else $error("Output set with an out of range date");

  property p_level_on;
    (eval_now && !mode.pulse && cfg_ok && active) |=> TIMER_Q_O;
  endproperty
  a_level_on: assert property (p_level_on)
    else $error("Active schedule left output low");

  property p_yearly_off;
    (eval_now && mode.yearly && !mode.monthly && !mode.pulse && !active)
      |=> !TIMER_Q_O;
  endproperty
  a_yearly_off: assert property (p_yearly_off)
    else $error("Yearly span held output outside its dates");

  property p_judge_once;
    eval_now ##1 ($stable(CAL_DATE_I) [*3]) |-> !eval_now;
  endproperty
  a_judge_once: assert property (p_judge_once)
    else $error("Same day judged twice");

  property p_repeat_years;
    (eval_now && repeating && (CAL_DATE_I.year < on_date.year ||
                               CAL_DATE_I.year > off_date.year))
      |=> !TIMER_Q_O;
  endproperty
  a_repeat_years: assert property (p_repeat_years)
    else $error("Repeating schedule switched outside its years");

  property p_monthly_on;
    (eval_now && mode.monthly && !mode.pulse && cfg_ok &&
     CAL_DATE_I.year >= on_date.year && CAL_DATE_I.year <= off_date.year &&
     CAL_DATE_I.day == on_date.day && on_date.day < off_date.day)
      |=> TIMER_Q_O;
  endproperty
  a_monthly_on: assert property (p_monthly_on)
    else $error("Monthly on day left output low");

  property p_span_on;
    (eval_now && ctrl[2:0] == 3'h0 && cfg_ok &&
     to_word(CAL_DATE_I) == on_word && on_word < off_word) |=> TIMER_Q_O;
  endproperty
  a_span_on: assert property (p_span_on)
    else $error("Single period did not open on its on date");

  property p_span_off;
    (eval_now && ctrl[2:0] == 3'h0 && to_word(CAL_DATE_I) == off_word)
      |=> !TIMER_Q_O;
  endproperty
  a_span_off: assert property (p_span_off)
    else $error("Single period still open on its off date");

  property p_status_out;
    (RD_I && ADDR_I == STATUS_OFF)
      |=> RDATA_O[STAT_OUT] == $past(TIMER_Q_O);
  endproperty
  a_status_out: assert property (p_status_out)
    else $error("Status read did not show the output level");

  property p_single_spent;
    (eval_now && pulse_single && spent && !wr_ctrl && !wr_on)
      |=> !TIMER_Q_O;
  endproperty
  a_single_spent: assert property (p_single_spent)
    else $error("Spent single pulse fired again");

  property p_yearly_pulse;
    (eval_now && mode.yearly && !mode.monthly && mode.pulse && cfg_ok &&
     CAL_DATE_I.year >= on_date.year && CAL_DATE_I.year <= off_date.year &&
     CAL_DATE_I.month == on_date.month && CAL_DATE_I.day == on_date.day &&
     state != ST_PULSE) |=> TIMER_Q_O;
  endproperty
  a_yearly_pulse: assert property (p_yearly_pulse)
    else $error("Yearly pulse missed its month and day");

endmodule // yearly_date_timer

/* File: shared/ydt_pkg.sv */
// Constants, types and helpers shared by the yearly date timer.
// Assumes a 10 MHz controller clock and a calendar that counts full years.
package ydt_pkg;

  // Calendar date as three ordered fields: year, month, day
  typedef struct packed {
    logic [11:0] year;
    logic [3:0]  month;
    logic [4:0]  day;
  } date_t;

  // Schedule options held in the control register
  typedef struct packed {
    logic pulse;
    logic monthly;
    logic yearly;
  } mode_t;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] ON_OFF     = 8'h04;
  localparam logic [7:0] OFFD_OFF   = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;
  localparam logic [7:0] NOW_OFF    = 8'h10;

  // Field positions of a date word
  localparam int YEAR_LSB  = 16;
  localparam int MONTH_LSB = 8;
  localparam int DAY_LSB   = 0;

  // Control register bits
  localparam int CTRL_YEARLY  = 0;
  localparam int CTRL_MONTHLY = 1;
  localparam int CTRL_PULSE   = 2;

  // Status register bits
  localparam int STAT_OUT   = 0;
  localparam int STAT_ON_OK = 1;
  localparam int STAT_OF_OK = 2;
  localparam int STAT_SPENT = 3;

  // Valid calendar span and field limits
  localparam logic [11:0] YEAR_MIN  = 12'h7D0;
  localparam logic [11:0] YEAR_MAX  = 12'h833;
  localparam logic [3:0]  MONTH_MAX = 4'hC;
  localparam logic [4:0]  DAY_MAX   = 5'h1F;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DATE_RST = 32'h07D0_0101;

  // Unpack a register word into its ordered date fields
  function automatic date_t to_date(input logic [31:0] w);
    date_t d;
    d.year  = w[YEAR_LSB +: 12];
    d.month = w[MONTH_LSB +: 4];
    d.day   = w[DAY_LSB +: 5];
    return d;
  endfunction

  // Pack date fields into a register word
  function automatic logic [31:0] to_word(input date_t d);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[YEAR_LSB +: 12] = d.year;
    w[MONTH_LSB +: 4] = d.month;
    w[DAY_LSB +: 5]   = d.day;
    return w;
  endfunction

endpackage

/* File: core/day_change_detect.sv */
// Scan-paced day change detector for the yearly date timer.
// Assumes the calendar inputs are stable and synchronous to the clock.
`timescale 1ns/1ps
module day_change_detect
  import ydt_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       scan_i,
  input  wire date_t      date_i,
  input  wire logic [4:0] hour_i,
  input  wire logic [5:0] min_i,
  output logic            eval_o,
  output logic            restore_o
);

  date_t last;
  logic  seen;
  wire   midnight = (hour_i == 5'h00) && (min_i == 6'h00);
  wire   new_date = (date_i != last);

  // First scan of a new day at 00:00, or first scan after reset
  assign eval_o    = scan_i && seen && new_date && midnight;
  assign restore_o = scan_i && !seen;

  // Remember the date seen at each scan
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last <= '0;
      seen <= 1'b0;
    end else if (scan_i) begin
      last <= date_i;
      seen <= 1'b1;
    end
  end

endmodule // day_change_detect

/* File: core/schedule_eval.sv */
// Combinational schedule evaluation for the yearly date timer.
// Assumes dates already checked for range by the caller.
`timescale 1ns/1ps
module schedule_eval
  import ydt_pkg::*;
(
  input  wire date_t mode_date_i,
  input  wire date_t on_i,
  input  wire date_t off_i,
  input  wire mode_t mode_i,
  output logic       active_o,
  output logic       hit_o
);

  // Position between lo and hi, hi exclusive, with wrap-around
  function automatic logic in_span(input logic [8:0] lo,
                                   input logic [8:0] hi,
                                   input logic [8:0] x);
    in_span = (lo <= hi) ? (x >= lo && x < hi) : (x >= lo || x < hi);
  endfunction

  date_t c;
  assign c = mode_date_i;

  wire [8:0]  cur_md = {c.month, c.day};
  wire [8:0]  on_md  = {on_i.month, on_i.day};
  wire [8:0]  off_md = {off_i.month, off_i.day};
  wire [8:0]  cur_d  = {4'h0, c.day};
  wire [8:0]  on_d   = {4'h0, on_i.day};
  wire [8:0]  off_d  = {4'h0, off_i.day};
  wire [20:0] cur_k  = {c.year, c.month, c.day};
  wire [20:0] on_k   = {on_i.year, on_i.month, on_i.day};
  wire [20:0] off_k  = {off_i.year, off_i.month, off_i.day};

  // Years from the on year through the off year
  wire in_years = (c.year >= on_i.year) && (c.year <= off_i.year);
  wire first_y  = (c.year == on_i.year);
  wire last_y   = (c.year == off_i.year);

  // Yearly span; a wrapping span never opens in the final year
  wire y_wrap = (off_md < on_md);
  wire y_span = in_span(on_md, off_md, cur_md);
  wire y_act  = in_years && y_span &&
                !(y_wrap && cur_md >= on_md && last_y) &&
                !(y_wrap && cur_md < off_md && first_y);

  // Monthly span, stopping after December of the off year
  wire m_wrap = (off_d < on_d);
  wire m_act  = in_years && in_span(on_d, off_d, cur_d) &&
                !(m_wrap && cur_d >= on_d && last_y &&
                  c.month == MONTH_MAX) &&
                !(m_wrap && cur_d < off_d && first_y && c.month == 4'h1);

  // One arbitrary period from full on date to full off date
  wire s_act = (cur_k >= on_k) && (cur_k < off_k);

  // Level result, monthly taking precedence over yearly
  assign active_o = mode_i.monthly ? m_act :
                    mode_i.yearly  ? y_act : s_act;

  // Pulse match; yearly pulses ignore the off month and day
  assign hit_o = mode_i.monthly ? (in_years && c.day == on_i.day) :
                 mode_i.yearly  ? (in_years && cur_md == on_md) :
                                  (cur_k == on_k);

endmodule // schedule_eval

/* File: testbench/cal_model.sv */
// Calendar source and scan pacer standing in front of the date timer.
// Assumes the bench names the wanted date and whether it is past 00:00.
`timescale 1ns/1ps
module cal_model
  import ydt_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  input  wire date_t want_i,
  input  wire logic  late_i,
  output date_t      date_o,
  output logic [4:0] hour_o,
  output logic [5:0] min_o,
  output logic       scan_o
);
  logic [1:0] phase;

  // Scan every fourth cycle, date taken two cycles ahead of it
  always_ff @(posedge clk_i) begin
    phase  <= rst_i ? 2'h0 : phase + 2'h1;
    scan_o <= !rst_i && phase == 2'h2;
    if (rst_i || phase == 2'h0) begin
      date_o <= want_i;
      hour_o <= late_i ? 5'h01 : 5'h00;
      min_o  <= late_i ? 6'h1E : 6'h00;
    end
  end
endmodule // cal_model

/* File: testbench/yearly_date_timer_bench.sv */
// Self-checking bench for the yearly date timer.
// Assumes the calendar model paces scans every four cycles.
`timescale 1ns/1ps
module yearly_date_timer_bench;
  import ydt_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [31:0] rdata;
  logic        scan;
  date_t       cal_date;
  logic [4:0]  cal_hour;
  logic [5:0]  cal_min;
  logic        timer_q;
  date_t       want = 21'h0FAE21;
  logic        late = 1'b0;
  logic        prev = 1'b0;
  logic [31:0] rises = 32'h0;
  logic [31:0] hi = 32'h0;
  logic [31:0] tab [0:35];
  int          num_errors = 0;
  int          checks = 0;
  int          cyc = 0;

  always #50 clk = ~clk;

  yearly_date_timer dut_u (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(bus_wr), .RD_I(bus_rd), .RDATA_O(rdata),
    .SCAN_I(scan), .CAL_DATE_I(cal_date), .CAL_HOUR_I(cal_hour),
    .CAL_MIN_I(cal_min), .TIMER_Q_O(timer_q));

  cal_model cal_u (.clk_i(clk), .rst_i(rst), .want_i(want),
    .late_i(late), .date_o(cal_date), .hour_o(cal_hour),
    .min_o(cal_min), .scan_o(scan));

  // Count output rises and high cycles; cut a hang short
  always @(posedge clk) begin
    if (timer_q === 1'b1) hi <= hi + 32'h1;
    if (timer_q === 1'b1 && prev !== 1'b1) rises <= rises + 32'h1;
    prev <= timer_q;
    cyc  <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    addr   <= a;
    wdata  <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(posedge clk);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    addr   <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    check("read data", exp, rdata);
    @(posedge clk);
  endtask

  task automatic cfg(input logic [31:0] m, input logic [31:0] on,
                     input logic [31:0] off);
    reg_wr(CTRL_OFF, m);
    reg_wr(ON_OFF, on);
    reg_wr(OFFD_OFF, off);
  endtask

  // Step word: late flag, level, pulse check, one pulse, then date
  task automatic step(input logic [31:0] s);
    logic [31:0] r0;
    logic [31:0] h0;
    want <= {s[27:16], s[11:8], s[4:0]};
    late <= s[31];
    #1;
    r0 = rises;
    h0 = hi;
    repeat (16) @(posedge clk);
    #1;
    check("output", {31'h0, s[30]}, {31'h0, timer_q});
    if (s[29]) begin
      check("pulses", {31'h0, s[28]}, rises - r0);
      if (s[28]) check("pulse length", 32'h4, hi - h0);
    end
    @(posedge clk);
  endtask

  task automatic run(input int lo, input int hi_i);
    for (int i = lo; i <= hi_i; i++) step(tab[i]);
  endtask

  // Main sequence
  initial begin
    tab = '{32'h07D7_0601, 32'h07D8_051F, 32'h87D8_0601, 32'h47D8_0602,
            32'h07D8_081F, 32'h47D9_0601, 32'hC7D9_081F, 32'h07D9_0901,
            32'h47DA_0601, 32'h07DA_081F, 32'h07DB_0601,
            32'h47D8_0C0F, 32'h07D9_0107, 32'h47D9_0C0F, 32'h07DA_0107,
            32'h07DA_0C0F,
            32'h07D8_051F, 32'h47D8_0601, 32'h47D9_0101, 32'h07DA_081F,
            32'h07DB_0601,
            32'h07D7_0C01, 32'h47D8_0301, 32'h07D8_0305, 32'h47DA_0C01,
            32'h07DA_0C05, 32'h07DB_0101,
            32'h07D8_0101,
            32'h37D8_030F, 32'h37D9_030F, 32'h27DB_030F,
            32'h37D8_030F, 32'h27D8_030E, 32'h27D8_030F,
            32'h37D8_040A, 32'h37D8_050A};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    reg_rd(CTRL_OFF, CTRL_RST);
    reg_rd(ON_OFF, DATE_RST);
    reg_rd(OFFD_OFF, DATE_RST);
    reg_rd(NOW_OFF, 32'h07D7_0101);
    reg_rd(8'h14, 32'h0);
    reg_wr(CTRL_OFF, 32'hFFFF_FFFF);
    reg_rd(CTRL_OFF, 32'h7);
    reg_wr(ON_OFF, 32'hFFFF_FFFF);
    reg_rd(ON_OFF, 32'h0FFF_0F1F);
    cfg(32'h1, 32'h07D8_0601, 32'h07DA_081F);
    run(0, 10);
    cfg(32'h1, 32'h07D8_0C0F, 32'h07DA_0107);
    run(11, 15);
    cfg(32'h0, 32'h07D8_0601, 32'h07DA_081F);
    run(16, 20);
    cfg(32'h2, 32'h07D8_0001, 32'h07DA_0005);
    run(21, 26);
    cfg(32'h0, 32'h07D8_0101, 32'h0834_0101);
    run(27, 27);
    reg_rd(STATUS_OFF, 32'h2);
    cfg(32'h5, 32'h07D8_030F, 32'h07DA_0101);
    run(28, 30);
    cfg(32'h4, 32'h07D8_030F, 32'h07DA_0101);
    run(31, 31);
    reg_rd(STATUS_OFF, 32'hE);
    run(32, 33);
    cfg(32'h6, 32'h07D8_000A, 32'h07D8_0001);
    run(34, 35);
    test_done();
  end
endmodule // yearly_date_timer_bench
